// file: pkg/conv_cfg_pkg.sv
// Constants and carrier types for the converter configuration register slice.
// Assumes a byte-wide register access port driven by the serial control port logic.
package conv_cfg_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_FULL_SCALE_LO = 8'h30;
    localparam logic [7:0] ADDR_FULL_SCALE_HI = 8'h31;
    localparam logic [7:0] ADDR_POWER_PROFILE = 8'h37;
    localparam logic [7:0] ADDR_TIMESTAMP = 8'h3B;
    localparam logic [7:0] ADDR_REF_OUT = 8'h3C;
    localparam logic [7:0] ADDR_FEEDBACK_DIV = 8'h3D;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] RST_FULL_SCALE = 16'hA000;
    localparam logic [7:0] RST_POWER_PROFILE = 8'h4B;
    localparam logic [7:0] RST_TIMESTAMP = 8'h00;
    localparam logic [7:0] RST_REF_OUT = 8'h01;
    localparam logic [7:0] RST_FEEDBACK_DIV = 8'h00;

    // ----------------------------------------
    // Field positions and codes
    // ----------------------------------------
    localparam int TS_ENABLE_BIT = 0;
    localparam int TS_PECL_BIT = 1;
    localparam int REF_OUT_EN_BIT = 0;
    localparam int FIRST_DIV_LSB = 0;
    localparam int SECOND_DIV_LSB = 2;
    localparam logic [7:0] PROFILE_LOW_POWER = 8'h46;
    localparam logic [7:0] PROFILE_HIGH_PERF = 8'h4B;
    localparam logic [15:0] FULL_SCALE_REC_MIN = 16'h2000;
    localparam logic [15:0] FULL_SCALE_MAX = 16'hFFFF;

    // Host register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Decoded synthesizer divider ratios
    typedef struct packed {
        logic [2:0] first_ratio;
        logic [2:0] second_ratio;
        logic first_reserved;
        logic second_reserved;
    } div_cfg_t;

endpackage

// file: rtl/converter_config_registers.sv
// Configuration register slice: full-scale, power profile, timestamp receiver,
// reference clock output and synthesizer feedback divider selects.
// Assumes single-cycle byte accesses from the control port, synchronous to clk_i.
`timescale 1ns/1ps

// Overview of operation
// - Sixteen-bit full-scale setting for all channels, resets to 0xA000.
// - Power profile 0x46 low power, 0x4B high performance default; others reserved.
// - Timestamp control bit 0 enables receiver; resets disabled.
// - Timestamp control bit 1 selects low-voltage PECL input mode.
// - Reference clock out active when enable bit and synthesizer enable set; resets one.
// - Second divider select: 0 div1, 1 div2, 2 div4, 3 reserved.
// - First divider select: 0 div5, 1 div4, 2 div3, 3 reserved.
module converter_config_registers (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input conv_cfg_pkg::reg_req_t req_i,
    input wire logic synth_enable_i,
    input wire logic synth_reset_i,
    input wire logic cal_enable_i,
    input wire logic serial_link_enable_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [15:0] full_scale_setting_o,
    output logic [7:0] power_profile_code_o,
    output logic profile_reserved_o,
    output logic timestamp_input_enable_o,
    output logic timestamp_pecl_mode_o,
    output logic reference_clock_out_o,
    output conv_cfg_pkg::div_cfg_t div_cfg_o,
    output logic div_change_unsafe_o,
    output logic profile_change_unsafe_o
);
    import conv_cfg_pkg::*;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    // Reserved bits are stored too, so a read returns exactly what the host wrote
    logic [15:0] full_scale;
    logic [7:0] power_profile;
    logic [7:0] timestamp_ctrl;
    logic [7:0] ref_out_ctrl;
    logic [7:0] feedback_div;
    logic [7:0] next_rdata;
    div_cfg_t next_div;

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // A control bit moved past the byte would read a bit no write can reach
    if (TS_ENABLE_BIT > 7 || TS_PECL_BIT > 7 || REF_OUT_EN_BIT > 7) begin : g_bit_range
        $error("control bit outside its register byte");
    end
    if (FIRST_DIV_LSB > 6 || SECOND_DIV_LSB > 6) begin : g_div_range
        $error("divider select outside its register byte");
    end
    // Both selects share one byte, so their two-bit fields must not overlap
    if ((FIRST_DIV_LSB + 2 > SECOND_DIV_LSB) &&
        (SECOND_DIV_LSB + 2 > FIRST_DIV_LSB)) begin : g_div_overlap
        $error("divider select fields overlap");
    end
    // The full-scale byte lanes are decoded as two adjacent offsets
    if (ADDR_FULL_SCALE_HI != ADDR_FULL_SCALE_LO + 8'h01) begin : g_fs_pair
        $error("full-scale byte lanes not adjacent");
    end
    // Two equal profile codes would make the two profiles indistinguishable
    if (PROFILE_LOW_POWER == PROFILE_HIGH_PERF) begin : g_profile_codes
        $error("profile codes not distinct");
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Full-scale range, two byte lanes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            full_scale <= RST_FULL_SCALE;
        end else if (req_i.wr && req_i.addr == ADDR_FULL_SCALE_LO) begin
            full_scale[7:0] <= req_i.wdata;
        end else if (req_i.wr && req_i.addr == ADDR_FULL_SCALE_HI) begin
            full_scale[15:8] <= req_i.wdata;
        end
    end

    // Power profile; every code is stored so reads match writes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            power_profile <= RST_POWER_PROFILE;
        end else if (req_i.wr && req_i.addr == ADDR_POWER_PROFILE) begin
            power_profile <= req_i.wdata;
        end
    end

    // Timestamp receiver controls, reserved bits kept as written
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timestamp_ctrl <= RST_TIMESTAMP;
        end else if (req_i.wr && req_i.addr == ADDR_TIMESTAMP) begin
            timestamp_ctrl <= req_i.wdata;
        end
    end

    // Reference output enable defaults on so the output runs unprogrammed
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ref_out_ctrl <= RST_REF_OUT;
        end else if (req_i.wr && req_i.addr == ADDR_REF_OUT) begin
            ref_out_ctrl <= req_i.wdata;
        end
    end

    // Feedback divider selects
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            feedback_div <= RST_FEEDBACK_DIV;
        end else if (req_i.wr && req_i.addr == ADDR_FEEDBACK_DIV) begin
            feedback_div <= req_i.wdata;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Unmapped offsets read as zero
    always_comb begin
        case (req_i.addr)
            ADDR_FULL_SCALE_LO: next_rdata = full_scale[7:0];
            ADDR_FULL_SCALE_HI: next_rdata = full_scale[15:8];
            ADDR_POWER_PROFILE: next_rdata = power_profile;
            ADDR_TIMESTAMP: next_rdata = timestamp_ctrl;
            ADDR_REF_OUT: next_rdata = ref_out_ctrl;
            ADDR_FEEDBACK_DIV: next_rdata = feedback_div;
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data holds until the next read, so a slow host may take it late
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                rdata_o <= next_rdata;
            end
        end
    end

    // ----------------------------------------
    // Divider decode
    // ----------------------------------------
    // Reserved codes flagged; ratio falls back to the reset ratio
    always_comb begin
        next_div = '0;
        // Second select sets the sampling clock ratio
        case (feedback_div[SECOND_DIV_LSB +: 2])
            2'h0: next_div.second_ratio = 3'h1;
            2'h1: next_div.second_ratio = 3'h2;
            2'h2: next_div.second_ratio = 3'h4;
            default: begin
                next_div.second_ratio = 3'h1;
                next_div.second_reserved = 1'b1;
            end
        endcase
        // First select feeds the second divider
        case (feedback_div[FIRST_DIV_LSB +: 2])
            2'h0: next_div.first_ratio = 3'h5;
            2'h1: next_div.first_ratio = 3'h4;
            2'h2: next_div.first_ratio = 3'h3;
            default: begin
                next_div.first_ratio = 3'h5;
                next_div.first_reserved = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // Registered outputs to the rest of the device
    // ----------------------------------------
    // One edge behind the registers; zero ratios show from reset until the first edge after its release
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            full_scale_setting_o <= RST_FULL_SCALE;
            power_profile_code_o <= RST_POWER_PROFILE;
            profile_reserved_o <= 1'b0;
            timestamp_input_enable_o <= 1'b0;
            timestamp_pecl_mode_o <= 1'b0;
            reference_clock_out_o <= 1'b0;
            div_cfg_o <= '0;
        end else begin
            full_scale_setting_o <= full_scale;
            power_profile_code_o <= power_profile;
            profile_reserved_o <= (power_profile != PROFILE_LOW_POWER) &&
                (power_profile != PROFILE_HIGH_PERF);
            timestamp_input_enable_o <= timestamp_ctrl[TS_ENABLE_BIT];
            timestamp_pecl_mode_o <= timestamp_ctrl[TS_PECL_BIT];
            reference_clock_out_o <= ref_out_ctrl[REF_OUT_EN_BIT] & synth_enable_i;
            div_cfg_o <= next_div;
        end
    end

    // Sticky warnings for host misuse; cleared only by reset, so they are diagnostic only
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_change_unsafe_o <= 1'b0;
            profile_change_unsafe_o <= 1'b0;
        end else begin
            if (req_i.wr && req_i.addr == ADDR_FEEDBACK_DIV && !synth_reset_i) begin
                div_change_unsafe_o <= 1'b1;
            end
            if (req_i.wr && req_i.addr == ADDR_POWER_PROFILE &&
                (cal_enable_i || serial_link_enable_i)) begin
                profile_change_unsafe_o <= 1'b1;
            end
        end
    end

endmodule

// file: tb/conv_cfg_asserts.sv
// Assertion checker for the configuration register slice.
// Assumes a bind to the top module and sees only its ports.
`timescale 1ns/1ps
module conv_cfg_asserts (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input conv_cfg_pkg::reg_req_t req_i,
    input wire logic synth_enable_i,
    input wire logic rvalid_o,
    input wire logic [15:0] full_scale_setting_o,
    input wire logic timestamp_input_enable_o,
    input wire logic timestamp_pecl_mode_o,
    input wire logic reference_clock_out_o,
    input conv_cfg_pkg::div_cfg_t div_cfg_o
);
    import conv_cfg_pkg::*;
    // ----------------
    // Port relations
    // ----------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Derived outputs lag a write by two edges
    a_read_answer: assert property (req_i.rd |=> rvalid_o)
        else $error("read not answered");
    a_stray_rvalid: assert property (!req_i.rd |=> !rvalid_o)
        else $error("stray read answer");
    a_ts_enable: assert property (req_i.wr && req_i.addr == ADDR_TIMESTAMP
        |=> ##1 timestamp_input_enable_o == $past(req_i.wdata[0], 2)) else $error("ts enable");
    a_ts_pecl: assert property (req_i.wr && req_i.addr == ADDR_TIMESTAMP
        |=> ##1 timestamp_pecl_mode_o == $past(req_i.wdata[1], 2)) else $error("ts mode");
    a_ref_gated: assert property (!synth_enable_i |=> !reference_clock_out_o)
        else $error("ref out without synth");
    a_fs_low: assert property (req_i.wr && req_i.addr == ADDR_FULL_SCALE_LO
        |=> ##1 full_scale_setting_o[7:0] == $past(req_i.wdata, 2)) else $error("fs low");
    a_first_div: assert property (req_i.wr && req_i.addr == ADDR_FEEDBACK_DIV
        && req_i.wdata[1:0] == 2'h2 |=> ##1 div_cfg_o.first_ratio == 3'h3) else $error("div1");
    a_second_div: assert property (req_i.wr && req_i.addr == ADDR_FEEDBACK_DIV
        && req_i.wdata[3:2] == 2'h2 |=> ##1 div_cfg_o.second_ratio == 3'h4) else $error("div2");
endmodule

bind converter_config_registers conv_cfg_asserts u_conv_cfg_asserts (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .req_i(req_i), .synth_enable_i(synth_enable_i), .rvalid_o(rvalid_o),
    .full_scale_setting_o(full_scale_setting_o), .div_cfg_o(div_cfg_o),
    .timestamp_input_enable_o(timestamp_input_enable_o),
    .timestamp_pecl_mode_o(timestamp_pecl_mode_o),
    .reference_clock_out_o(reference_clock_out_o));

// file: tb/converter_config_registers_tb.sv
// Self-checking bench for the configuration register slice.
// Assumes the host model and the bound checker from tb/.
`timescale 1ns/1ps
module converter_config_registers_tb;
    import conv_cfg_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic synth_en = 1'b1;
    logic synth_rst = 1'b1;
    logic cal_en = 1'b0;
    logic link_en = 1'b0;
    reg_req_t req;
    div_cfg_t div;
    logic [7:0] rdata_o, prof, d, e;
    logic [15:0] fs;
    logic rvalid_o, prof_res, ts_en, ts_pecl, ref_out, div_bad, prof_bad;
    int fails = 0;
    int num_checks = 0;
    logic [7:0] exp_q[$];
    logic [7:0] adr[7] = '{8'h30, 8'h31, 8'h37, 8'h3B, 8'h3C, 8'h3D, 8'h40};
    logic [7:0] rst[7] = '{8'h00, 8'hA0, 8'h4B, 8'h00, 8'h01, 8'h00, 8'h00};
    initial forever #2.5 clk_i = ~clk_i;
    host_port_model u_host_port_model (.clk_i(clk_i), .req_o(req));
    converter_config_registers u_converter_config_registers (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .req_i(req), .synth_enable_i(synth_en), .synth_reset_i(synth_rst),
        .cal_enable_i(cal_en), .serial_link_enable_i(link_en), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .full_scale_setting_o(fs), .power_profile_code_o(prof),
        .profile_reserved_o(prof_res), .timestamp_input_enable_o(ts_en),
        .timestamp_pecl_mode_o(ts_pecl), .reference_clock_out_o(ref_out), .div_cfg_o(div),
        .div_change_unsafe_o(div_bad), .profile_change_unsafe_o(prof_bad));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host_port_model.access(1'b0, 1'b1, a, 8'h00);
    endtask
    // Derived outputs follow a write one edge after the register takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_host_port_model.access(1'b1, 1'b0, a, v);
        @(posedge clk_i);
        #1;
    endtask
    // Every mapped offset and one unmapped offset against its reset value
    task automatic reset_reads();
        for (int i = 0; i < 7; i++) rd(adr[i], rst[i]);
        check(fs, 16'hA000);
        check(16'({ref_out, ts_pecl, ts_en}), 16'h0004);
    endtask
    task automatic conclude();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Oldest noted read result against each answer
    always @(negedge clk_i) begin
        if (rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) check(16'h0001, 16'h0000);
            else check(16'(rdata_o), 16'(exp_q.pop_front()));
        end
    end
    initial begin
        #50_000;
        fails++;
        conclude();
    end
    initial begin
        void'($urandom(32'h1254_83ec));
        repeat (8) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        reset_reads();
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            e = 8'($urandom);
            wr(8'h30, e);
            d = 8'($urandom_range(32, 255));
            wr(8'h31, d);
            check(fs, {d, e});
            rd(8'h30, e);
            d = 8'($urandom) & 8'h03;
            wr(8'h3B, d);
            check(16'({ts_pecl, ts_en}), 16'(d));
            rd(8'h3B, d);
        end
        $display("test random done");
        for (int c = 0; c < 16; c++) begin
            wr(8'h3D, 8'(c));
            check(16'(div.first_ratio), (c % 4 == 3) ? 16'h0005 : 16'(5 - c % 4));
            check(16'(div.second_ratio), (c / 4 == 3) ? 16'h0001 : 16'(1 << (c / 4)));
            check(16'({div.first_reserved, div.second_reserved, div_bad}),
                  16'({c % 4 == 3, c / 4 == 3, 1'b0}));
        end
        synth_rst = 1'b0;
        wr(8'h3D, 8'h00);
        check(16'(div_bad), 16'h0001);
        synth_rst = 1'b1;
        $display("test divider done");
        // Companion profile registers live outside this slice
        wr(8'h37, 8'h46);
        check(16'({prof, prof_res, prof_bad}), 16'h0118);
        // Calibration run after the profile change
        cal_en = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        cal_en = 1'b0;
        wr(8'h37, 8'h50);
        check(16'({prof_res, prof_bad}), 16'h0002);
        cal_en = 1'b1;
        wr(8'h37, 8'h4B);
        check(16'({prof_res, prof_bad}), 16'h0001);
        cal_en = 1'b0;
        $display("test profile done");
        // Mid-run reset clears the sticky flags and restores every register
        arst_n_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        check(16'({prof_bad, div_bad, rvalid_o}), 16'h0000);
        arst_n_i = 1'b1;
        reset_reads();
        link_en = 1'b1;
        wr(8'h37, 8'h4B);
        check(16'(prof_bad), 16'h0001);
        link_en = 1'b0;
        $display("test midrun reset done");
        wr(8'h3C, 8'h00);
        check(16'(ref_out), 16'h0000);
        wr(8'h3C, 8'h01);
        check(16'(ref_out), 16'h0001);
        synth_en = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        check(16'(ref_out), 16'h0000);
        repeat (4) @(posedge clk_i);
        check(16'(exp_q.size()), 16'h0000);
        $display("test refclk done");
        conclude();
    end
endmodule

// file: tb/host_port_model.sv
// Host side of the register port: one access at a time.
// Assumes the block takes requests on the rising clock edge.
`timescale 1ns/1ps
module host_port_model (
    input wire logic clk_i,
    output conv_cfg_pkg::reg_req_t req_o
);
    import conv_cfg_pkg::*;
    initial req_o = '0;
    // Random idle gaps make the host slow at times; idle bus shows no stale data
    task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        repeat ($urandom_range(1, 3)) @(posedge clk_i);
        #1;
        req_o = '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk_i);
        #1;
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule
